// ### hdl/dpsa_pkg.sv
// constants and carrier types for the debug and pointer-auth syndrome block
package dpsa_pkg;

    // syndrome layout
    localparam int         ISS_W        = 25;
    localparam int         SVALID_POS   = 24;
    localparam int         EXCL_POS     = 6;
    localparam int         MAINT_POS    = 8;
    localparam int         WFLAG_POS    = 6;
    localparam int         DKEY_POS     = 1;
    localparam int         BKEY_POS     = 0;
    localparam logic [5:0] FSC_DEBUG    = 6'h22;
    localparam logic [5:0] EC_SYS_TRAP  = 6'h18;

    // system instruction encoding of the el1 syndrome register
    localparam logic [1:0] ENC_OP0      = 2'h3;
    localparam logic [2:0] ENC_OP1      = 3'h0;
    localparam logic [3:0] ENC_CRN      = 4'h5;
    localparam logic [3:0] ENC_CRM      = 4'h2;
    localparam logic [2:0] ENC_OP2      = 3'h0;

    // exception levels
    localparam logic [1:0] EL0          = 2'h0;
    localparam logic [1:0] EL1          = 2'h1;
    localparam logic [1:0] EL2          = 2'h2;
    localparam logic [1:0] EL3          = 2'h3;

    // watchpoint comparators
    localparam int         WP_N         = 4;
    localparam int         WP_IDX_W     = 2;

    // register bus map, byte addresses
    localparam logic [3:0] OFF_CONFIG   = 4'h0;
    localparam logic [3:0] OFF_EL1_SYN  = 4'h4;
    localparam logic [3:0] OFF_EL2_SYN  = 4'h8;
    localparam logic [3:0] OFF_STATUS   = 4'hC;
    localparam logic [14:0] CFG_RESET   = 15'h0000;
    localparam logic [31:0] SYN_RESET   = 32'h00000000;

    typedef enum logic [1:0] {
        KIND_SSTEP = 2'h0,
        KIND_WATCH = 2'h1,
        KIND_BRK   = 2'h2,
        KIND_AUTH  = 2'h3
    } dpsa_kind_type;

    // software configuration, msb first
    typedef struct packed {
        logic       comb_fault;
        logic       monitor_pauth_enable;
        logic       hyp_pauth_enable;
        logic       host_extension_bit;
        logic       trap_vm_writes_bit;
        logic       trap_vm_reads_bit;
        logic       el2_is_64;
        logic       el2_enabled;
        logic [1:0] cap_target_el;
        logic       halted;
        logic       cap_access_en;
        logic       cap_present;
        logic [1:0] current_exception_level;
    } dpsa_cfg_type;

    typedef struct packed {
        logic          valid;
        dpsa_kind_type kind;
        logic          to_el2;
        logic          syndrome_valid_bit;
        logic          exclusive_load_stepped;
        logic          cache_maint;
        logic          zero_cache_block_instr;
        logic          is_write;
        logic          is_atomic;
        logic          atomic_read_hit;
        logic [15:0]   comment;
        logic          data_key;
        logic          b_key;
        logic          auth_bad;
        logic          combined;
    } dpsa_event_type;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [1:0]  op0;
        logic [2:0]  op1;
        logic [3:0]  crn;
        logic [3:0]  crm;
        logic [2:0]  op2;
        logic [31:0] wdata;
    } dpsa_sysreq_type;

    typedef struct packed {
        logic        done;
        logic        claimed;
        logic        undef;
        logic        trap;
        logic [1:0]  trap_el;
        logic [5:0]  ec;
        logic [31:0] rdata;
    } dpsa_sysresp_type;

endpackage

// ### hdl/dpsa_syndrome.sv
// syndrome capture and system-register access checks for el1/el2 syndromes
`timescale 1ns/1ps
`default_nettype none

module dpsa_syndrome
    import dpsa_pkg::*;
(
    input  wire logic                  i_clock,
    input  wire logic                  i_resetn,
    input  wire dpsa_event_type        i_event,
    input  wire logic [WP_N-1:0]       i_wp_match,
    input  wire dpsa_sysreq_type       i_sys_req,
    output var dpsa_sysresp_type       o_sys_resp,
    output logic                       o_exc_taken,
    output logic [ISS_W-1:0]           o_exc_iss,
    output logic [WP_IDX_W-1:0]        o_wp_source,
    input  wire logic [3:0]            i_avs_address,
    input  wire logic                  i_avs_read,
    input  wire logic                  i_avs_write,
    input  wire logic [31:0]           i_avs_writedata,
    input  wire logic [3:0]            i_avs_byteenable,
    output logic [31:0]                o_avs_readdata,
    output logic                       o_avs_waitrequest
);

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    dpsa_cfg_type          cfg;
    logic [31:0]           el1_syn;
    logic [31:0]           el2_syn;
    logic [ISS_W-1:0]      next_iss;
    logic                  next_take;
    logic                  maint_eff;
    logic                  pauth_off;
    logic [WP_IDX_W-1:0]   next_wp_source;
    logic [WP_N-1:0]       wp_match_q;
    logic                  sys_hit;
    logic                  cap_block;
    logic                  next_undef;
    logic                  next_trap;
    logic [1:0]            next_trap_el;
    logic                  next_use_el2;
    logic                  sys_ok;
    logic                  avs_ack;
    logic                  avs_req;

    ////////////////////////////////////////////////////////////////////////
    // syndrome assembly for the four exception kinds

    // zero cache block is no cache maintenance op
    assign maint_eff = i_event.cache_maint & ~i_event.zero_cache_block_instr;
    assign pauth_off = ~cfg.hyp_pauth_enable | ~cfg.monitor_pauth_enable;

    // reserved bits stay zero because the vector starts cleared
    always_comb begin
        next_iss  = '0;
        next_take = 1'b0;
        unique case (i_event.kind)
            KIND_SSTEP: begin
                next_take            = i_event.valid;
                next_iss[5:0]        = FSC_DEBUG;
                next_iss[SVALID_POS] = i_event.syndrome_valid_bit;
                // exclusive bit only meaningful with valid syndrome
                next_iss[EXCL_POS]   = i_event.syndrome_valid_bit
                                     & i_event.exclusive_load_stepped;
            end
            KIND_WATCH: begin
                next_take           = i_event.valid;
                next_iss[5:0]       = FSC_DEBUG;
                next_iss[MAINT_POS] = maint_eff;
                if (maint_eff) begin
                    next_iss[WFLAG_POS] = 1'b1;
                end else if (i_event.is_atomic) begin
                    next_iss[WFLAG_POS] = ~i_event.atomic_read_hit;
                end else begin
                    next_iss[WFLAG_POS] = i_event.is_write;
                end
            end
            KIND_BRK: begin
                next_take          = i_event.valid;
                next_iss[15:0]     = i_event.comment;
            end
            KIND_AUTH: begin
                if (pauth_off) begin
                    // trapped instruction carries no detail
                    next_take = i_event.valid;
                end else if (i_event.auth_bad
                             & (~i_event.combined | cfg.comb_fault)) begin
                    next_take          = i_event.valid;
                    next_iss[DKEY_POS] = i_event.data_key;
                    next_iss[BKEY_POS] = i_event.b_key;
                end
            end
        endcase
    end

    // lowest matching comparator wins; any choice is legal
    always_comb begin
        next_wp_source = '0;
        for (int k = WP_N - 1; k >= 0; k--) begin
            if (i_wp_match[k]) begin
                next_wp_source = WP_IDX_W'(k);
            end
        end
    end

    // last taken exception, for the pipeline and for software
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_exc_taken <= 1'b0;
            o_exc_iss   <= '0;
            o_wp_source <= '0;
            wp_match_q  <= '0;
        end else begin
            o_exc_taken <= next_take;
            wp_match_q  <= i_wp_match;
            if (next_take) begin
                o_exc_iss <= next_iss;
            end
            if (i_event.valid && i_event.kind == KIND_WATCH) begin
                o_wp_source <= next_wp_source;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // system instruction access checks

    assign sys_hit   = i_sys_req.valid
                     && i_sys_req.op0 == ENC_OP0 && i_sys_req.op1 == ENC_OP1
                     && i_sys_req.crn == ENC_CRN && i_sys_req.crm == ENC_CRM
                     && i_sys_req.op2 == ENC_OP2;
    assign cap_block = cfg.cap_present & ~cfg.cap_access_en & ~cfg.halted;

    // privilege and capability gating, highest priority first
    always_comb begin
        next_undef   = 1'b0;
        next_trap    = 1'b0;
        next_trap_el = EL1;
        next_use_el2 = 1'b0;
        unique case (cfg.current_exception_level)
            EL0: begin
                next_undef = 1'b1;
            end
            EL1: begin
                if (cap_block) begin
                    next_trap    = 1'b1;
                    // target code zero falls back to el1
                    next_trap_el = (cfg.cap_target_el == EL0) ? EL1 : cfg.cap_target_el;
                end else if (cfg.el2_enabled && cfg.el2_is_64
                             && (i_sys_req.write ? cfg.trap_vm_writes_bit
                                                 : cfg.trap_vm_reads_bit)) begin
                    next_trap    = 1'b1;
                    next_trap_el = EL2;
                end
            end
            EL2: begin
                if (cap_block) begin
                    next_trap    = 1'b1;
                    next_trap_el = (cfg.cap_target_el == EL2) ? EL2 : EL3;
                end else begin
                    next_use_el2 = cfg.host_extension_bit;
                end
            end
            EL3: begin
                // no ordering against alias accesses is enforced here
                if (cap_block) begin
                    next_trap    = 1'b1;
                    next_trap_el = EL3;
                end
            end
        endcase
    end

    assign sys_ok = sys_hit & ~next_undef & ~next_trap;

    // one-cycle registered answer to every request
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sys_resp <= '0;
        end else begin
            o_sys_resp.done    <= i_sys_req.valid;
            o_sys_resp.claimed <= sys_hit;
            o_sys_resp.undef   <= sys_hit & next_undef;
            o_sys_resp.trap    <= sys_hit & next_trap;
            o_sys_resp.trap_el <= (sys_hit & next_trap) ? next_trap_el : EL0; // zero unless trapped
            o_sys_resp.ec      <= (sys_hit & next_trap) ? EC_SYS_TRAP : 6'h00;
            o_sys_resp.rdata   <= (sys_ok & ~i_sys_req.write)
                                ? (next_use_el2 ? el2_syn : el1_syn) : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // syndrome storage

    // contents are don't-care after reset; cleared only for tidiness
    // an exception in the same cycle as a move to the register wins
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            el1_syn <= SYN_RESET;
            el2_syn <= SYN_RESET;
        end else begin
            if (sys_ok && i_sys_req.write) begin
                if (next_use_el2) begin
                    el2_syn <= i_sys_req.wdata;
                end else begin
                    el1_syn <= i_sys_req.wdata;
                end
            end
            if (next_take) begin
                if (i_event.to_el2) begin
                    el2_syn <= 32'(next_iss);
                end else begin
                    el1_syn <= 32'(next_iss);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // avalon-mm slave, one wait state on every access

    assign avs_req           = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = avs_req & ~avs_ack;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            avs_ack <= 1'b0;
        end else begin
            avs_ack <= avs_req & ~avs_ack;
        end
    end

    // read data latched during the wait state so it is stable at the ack
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_avs_readdata <= 32'h00000000;
        end else if (i_avs_read && !avs_ack) begin
            unique case (i_avs_address)
                OFF_CONFIG:  o_avs_readdata <= 32'(cfg);
                OFF_EL1_SYN: o_avs_readdata <= el1_syn;
                OFF_EL2_SYN: o_avs_readdata <= el2_syn;
                OFF_STATUS:  o_avs_readdata <= {24'h000000, o_wp_source,
                                                o_sys_resp.trap_el, o_sys_resp.trap,
                                                o_sys_resp.undef, o_sys_resp.claimed,
                                                o_exc_taken};
                default:     o_avs_readdata <= 32'h00000000;
            endcase
        end
    end

    // configuration write honours byte enables; other offsets ignore writes
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            cfg <= dpsa_cfg_type'(CFG_RESET);
        end else if (i_avs_write && avs_ack && i_avs_address == OFF_CONFIG) begin
            if (i_avs_byteenable[0]) begin
                cfg[7:0] <= i_avs_writedata[7:0];
            end
            if (i_avs_byteenable[1]) begin
                cfg[14:8] <= i_avs_writedata[14:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    AST_SSTEP_FSC: assert property (
        i_event.valid && i_event.kind == KIND_SSTEP |=> o_exc_taken && o_exc_iss[5:0] == FSC_DEBUG)
        else $error("step fault code wrong");
    AST_SSTEP_EXCL_ZERO: assert property (
        i_event.valid && i_event.kind == KIND_SSTEP && !i_event.syndrome_valid_bit
        |=> !o_exc_iss[EXCL_POS] && !o_exc_iss[SVALID_POS])
        else $error("exclusive bit set without valid syndrome");
    AST_SSTEP_EXV: assert property (
        i_event.valid && i_event.kind == KIND_SSTEP && i_event.syndrome_valid_bit
        |=> o_exc_iss[EXCL_POS] == $past(i_event.exclusive_load_stepped))
        else $error("exclusive bit does not follow stepped load");
    AST_WP_MAINT: assert property (
        i_event.valid && i_event.kind == KIND_WATCH |=> o_exc_iss[5:0] == FSC_DEBUG
        && o_exc_iss[MAINT_POS] == ($past(i_event.cache_maint)
                                    && !$past(i_event.zero_cache_block_instr)))
        else $error("maintenance flag wrong");
    AST_WP_ZERO_BLOCK: assert property (
        i_event.valid && i_event.kind == KIND_WATCH && i_event.zero_cache_block_instr
        |=> !o_exc_iss[MAINT_POS])
        else $error("zero block set maintenance flag");
    AST_WP_WRITE: assert property (
        i_event.valid && i_event.kind == KIND_WATCH && !i_event.cache_maint
        && !i_event.is_atomic |=> o_exc_iss[WFLAG_POS] == $past(i_event.is_write))
        else $error("write flag does not follow access");
    AST_WP_MAINT_WRITE: assert property (
        i_event.valid && i_event.kind == KIND_WATCH && i_event.cache_maint
        && !i_event.zero_cache_block_instr |=> o_exc_iss[WFLAG_POS])
        else $error("maintenance watchpoint not reported as write");
    AST_WP_ATOM: assert property (
        i_event.valid && i_event.kind == KIND_WATCH && !i_event.cache_maint
        && i_event.is_atomic |=> o_exc_iss[WFLAG_POS] != $past(i_event.atomic_read_hit))
        else $error("atomic write flag wrong");
    AST_WP_SRC: assert property (
        i_event.valid && i_event.kind == KIND_WATCH && i_wp_match != '0
        |=> wp_match_q[o_wp_source])
        else $error("reported watchpoint did not match");
    AST_BRK_COMMENT: assert property (
        i_event.valid && i_event.kind == KIND_BRK
        |=> o_exc_iss[15:0] == $past(i_event.comment) && o_exc_iss[24:16] == '0)
        else $error("breakpoint comment wrong");
    AST_AUTH_TRAP: assert property (
        i_event.valid && i_event.kind == KIND_AUTH
        && (!cfg.hyp_pauth_enable || !cfg.monitor_pauth_enable)
        |=> o_exc_taken && o_exc_iss == '0)
        else $error("pointer-auth trap syndrome not zero");
    AST_AUTH_FAIL: assert property (
        i_event.valid && i_event.kind == KIND_AUTH && cfg.hyp_pauth_enable
        && cfg.monitor_pauth_enable && i_event.auth_bad && !i_event.combined
        |=> o_exc_taken && o_exc_iss[24:2] == '0
        && o_exc_iss[1] == $past(i_event.data_key) && o_exc_iss[0] == $past(i_event.b_key))
        else $error("authentication failure syndrome wrong");
    AST_EL0_UNDEF: assert property (
        sys_hit && cfg.current_exception_level == EL0
        |=> o_sys_resp.done && o_sys_resp.undef && !o_sys_resp.trap)
        else $error("el0 access not undefined");
    AST_CAP_TRAP: assert property (
        sys_hit && cap_block && cfg.current_exception_level == EL3
        |=> o_sys_resp.trap && o_sys_resp.trap_el == EL3 && o_sys_resp.ec == EC_SYS_TRAP)
        else $error("capability trap missing");
    AST_VM_READ_TRAP: assert property (
        sys_hit && !i_sys_req.write && !cap_block && cfg.current_exception_level == EL1
        && cfg.el2_enabled && cfg.el2_is_64 && cfg.trap_vm_reads_bit
        |=> o_sys_resp.trap && o_sys_resp.trap_el == EL2 && o_sys_resp.ec == EC_SYS_TRAP)
        else $error("vm read trap missing");
    AST_HOST_EXT_READ: assert property (
        sys_hit && !i_sys_req.write && !cap_block && cfg.current_exception_level == EL2
        |=> o_sys_resp.rdata == ($past(cfg.host_extension_bit) ? $past(el2_syn)
                                                               : $past(el1_syn)))
        else $error("el2 read returned wrong register");
    AST_DECODE: assert property (
        i_sys_req.valid && i_sys_req.crn != ENC_CRN |=> o_sys_resp.done && !o_sys_resp.claimed)
        else $error("foreign encoding claimed");

endmodule // dpsa_syndrome

`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the debug and pointer-auth syndrome block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import dpsa_pkg::*;

    logic                i_clock         = 1'b0;
    logic                i_resetn        = 1'b0;
    dpsa_event_type      ev_in           = '0;
    logic [WP_N-1:0]     wp              = '0;
    dpsa_sysreq_type     req             = '0;
    dpsa_sysresp_type    rsp;
    logic                taken;
    logic [ISS_W-1:0]    iss;
    logic [WP_IDX_W-1:0] src;
    logic [3:0]          adr             = 4'h0;
    logic                rd              = 1'b0;
    logic                wr              = 1'b0;
    logic [31:0]         wdat            = 32'h0;
    logic [3:0]          be              = 4'hF;
    logic [31:0]         rdat;
    logic                wait_rq;
    int                  n_fail          = 0;
    int                  samples_checked = 0;
    int                  cycles          = 0;
    dpsa_cfg_type        cfg             = '0;
    logic [31:0]         v;

    ////////////////////////////////////////////////////////////////////////
    // 200 MHz clock and design under test
    always #2.5 i_clock = ~i_clock;

    dpsa_syndrome dut (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_event(ev_in), .i_wp_match(wp),
        .i_sys_req(req), .o_sys_resp(rsp), .o_exc_taken(taken), .o_exc_iss(iss),
        .o_wp_source(src), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdat), .i_avs_byteenable(be), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wait_rq)
    );

    ////////////////////////////////////////////////////////////////////////
    // verdict and watchdog; the ceiling is generous against ~115 busy cycles
    task automatic finish_test();
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // avalon access; request held until waitrequest is seen low at a rising edge
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge i_clock);
        rd   <= ~w;
        wr   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge i_clock);
        end while (wait_rq !== 1'b0);
        q  = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic set_cfg();
        av(1'b1, OFF_CONFIG, {17'h0, cfg}, v);
    endtask

    // one event pulse; f = {to_el2, svalid, excl, maint, zero_blk, write, atomic, read_hit}
    task automatic fire(input dpsa_kind_type k, input logic [7:0] f, input logic [15:0] c,
                        input logic [3:0] p, input logic tk, input logic [31:0] exp);
        @(posedge i_clock);
        ev_in <= {1'b1, k, f, c, p};
        @(posedge i_clock);
        ev_in.valid <= 1'b0;
        #1;
        chk({31'h0, taken}, {31'h0, tk});
        if (tk) chk({7'h0, iss}, exp);
    endtask

    function automatic logic [11:0] fl(input logic c, input logic u, input logic t,
                                       input logic [1:0] el);
        return {1'b1, c, u, t, el, (t ? EC_SYS_TRAP : 6'h00)};
    endfunction

    // system register move; flags = {done, claimed, undef, trap, trap_el, ec}
    task automatic sys(input logic w, input logic [3:0] crm, input logic [31:0] d,
                       input logic [11:0] fx, input logic [31:0] rx);
        @(posedge i_clock);
        req <= {1'b1, w, ENC_OP0, ENC_OP1, ENC_CRN, crm, ENC_OP2, d};
        @(posedge i_clock);
        req.valid <= 1'b0;
        #1;
        chk({20'h0, rsp.done, rsp.claimed, rsp.undef, rsp.trap, rsp.trap_el, rsp.ec}, {20'h0, fx});
        if (!w) chk(rsp.rdata, rx);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (12) @(posedge i_clock);
        i_resetn <= 1'b1;
        av(1'b0, 4'h2, 32'h0, v);
        chk(v, 32'h0);                                          // unmapped offset reads zero
        sys(1'b0, ENC_CRM, 32'h0, fl(1, 1, 0, EL0), 32'h0);
        sys(1'b1, ENC_CRM, 32'h5, fl(1, 1, 0, EL0), 32'h0);
        cfg.current_exception_level = EL1;
        cfg.el2_enabled = 1'b1;
        cfg.el2_is_64 = 1'b1;
        cfg.trap_vm_reads_bit = 1'b1;
        set_cfg();
        av(1'b0, OFF_CONFIG, 32'h0, v);
        chk(v, {17'h0, cfg});                                    // config reads back
        sys(1'b0, ENC_CRM, 32'h0, fl(1, 0, 1, EL2), 32'h0);
        sys(1'b1, ENC_CRM, 32'h00ABCDEF, fl(1, 0, 0, EL0), 32'h0);
        sys(1'b0, 4'h3, 32'h0, 12'h800, 32'h0);
        cfg.trap_vm_reads_bit = 1'b0;
        set_cfg();
        sys(1'b0, ENC_CRM, 32'h0, fl(1, 0, 0, EL0), 32'h00ABCDEF);
        cfg.cap_present = 1'b1;
        cfg.cap_target_el = EL1;
        set_cfg();
        sys(1'b0, ENC_CRM, 32'h0, fl(1, 0, 1, EL1), 32'h0);
        cfg.current_exception_level = EL3;
        set_cfg();
        sys(1'b1, ENC_CRM, 32'h0, fl(1, 0, 1, EL3), 32'h0);
        cfg.halted = 1'b1;
        set_cfg();
        sys(1'b0, ENC_CRM, 32'h0, fl(1, 0, 0, EL0), 32'h00ABCDEF);
        // syndrome events
        fire(KIND_SSTEP, 8'h20, 16'h0, 4'h0, 1'b1, 32'h22);
        fire(KIND_SSTEP, 8'h60, 16'h0, 4'h0, 1'b1, 32'h01000062);
        fire(KIND_SSTEP, 8'h40, 16'h0, 4'h0, 1'b1, 32'h01000022);
        fire(KIND_WATCH, 8'h00, 16'h0, 4'h0, 1'b1, 32'h22);
        fire(KIND_WATCH, 8'h04, 16'h0, 4'h0, 1'b1, 32'h62);
        fire(KIND_WATCH, 8'h10, 16'h0, 4'h0, 1'b1, 32'h162);
        fire(KIND_WATCH, 8'h1C, 16'h0, 4'h0, 1'b1, 32'h62);
        fire(KIND_WATCH, 8'h07, 16'h0, 4'h0, 1'b1, 32'h22);
        @(posedge i_clock);
        wp <= 4'hA;
        fire(KIND_WATCH, 8'h06, 16'h0, 4'h0, 1'b1, 32'h62);
        chk({30'h0, src}, 32'h1);
        av(1'b0, OFF_STATUS, 32'h0, v);
        chk(v, 32'h40);
        av(1'b0, OFF_EL1_SYN, 32'h0, v);
        chk(v, 32'h62);
        fire(KIND_BRK, 8'h80, 16'h1234, 4'h0, 1'b1, 32'h1234);
        fire(KIND_BRK, 8'h00, 16'hFFFF, 4'h0, 1'b1, 32'hFFFF);
        av(1'b0, OFF_EL2_SYN, 32'h0, v);
        chk(v, 32'h1234);
        // host extension picks the el2 syndrome at el2
        cfg = '0;
        cfg.current_exception_level = EL2;
        cfg.host_extension_bit = 1'b1;
        set_cfg();
        sys(1'b0, ENC_CRM, 32'h0, fl(1, 0, 0, EL0), 32'h1234);
        cfg.host_extension_bit = 1'b0;
        set_cfg();
        sys(1'b0, ENC_CRM, 32'h0, fl(1, 0, 0, EL0), 32'hFFFF);
        // pointer authentication with one enable off, then both on
        cfg.monitor_pauth_enable = 1'b1;
        set_cfg();
        fire(KIND_AUTH, 8'h00, 16'hFFFF, 4'h0, 1'b1, 32'h0);
        cfg.hyp_pauth_enable = 1'b1;
        set_cfg();
        fire(KIND_AUTH, 8'h00, 16'h0, 4'hA, 1'b1, 32'h2);
        fire(KIND_AUTH, 8'h00, 16'h0, 4'h6, 1'b1, 32'h1);
        fire(KIND_AUTH, 8'h00, 16'h0, 4'hC, 1'b0, 32'h0);
        fire(KIND_AUTH, 8'h00, 16'h0, 4'h3, 1'b0, 32'h0);
        cfg.comb_fault = 1'b1;
        set_cfg();
        fire(KIND_AUTH, 8'h00, 16'h0, 4'hF, 1'b1, 32'h3);
        finish_test();
    end

endmodule // tb_top

`default_nettype wire
